// ---- rtl/timer_pkg.sv ----
// package: register map, fields, reset values and prescale for the dual timer block
// ----------------------------------------------------------------------------
// Operation
// - timer 0 advances at system clock /12 when its fast bit is 0, else /1.
// - timer 1 advances at system clock /12 when its fast bit is 0, else /1.
// - baud clock output toggles on each baud timer overflow when enabled.
// - timer 1 clock output toggles on each timer 1 overflow when enabled.
// - timer 0 clock output toggles on each timer 0 overflow when enabled.
// - gate set needs run bit and external pin high; gate clear needs run only.
// - function bit clear counts internal ticks; set counts external pin events.
// - mode 00 is a 13-bit timer/counter.
// - mode 01 cascades high and low bytes into 16 bits, no prescaler.
// - mode 10 counts low byte, reloaded from high byte on overflow.
// - timer 0 mode 11 splits low byte (timer 0 controls), high byte (timer 1).
// - timer 1 in mode 11 stops counting.
// - mode register holds two gate/function/mode groups, upper for timer 1.
// - timer 1 overflow flag set on overflow, cleared on interrupt vectoring.
// - timer 0 overflow flag set on overflow, cleared on interrupt vectoring.
// - control bit 6 is software run control of timer 1.
// - control bit 4 is software run control of timer 0.
// - external interrupt flag set on detection, cleared when processed.
// - external interrupt type bit selects falling edge (1) or low level (0).
// - count pin sampled each clock; high then low sample increments.
// - 13-bit mode uses eight high bits and five low bits.
// - auto-reload leaves the high byte unchanged.
// - split high byte uses timer 1 run bit and sets timer 1 overflow flag.
// ----------------------------------------------------------------------------
package timer_pkg;
  // register offsets on the plain port
  localparam logic [2:0] OFS_CONTROL   = 3'h0;
  localparam logic [2:0] OFS_MODE      = 3'h1;
  localparam logic [2:0] OFS_LOW_ZERO  = 3'h2;
  localparam logic [2:0] OFS_LOW_ONE   = 3'h3;
  localparam logic [2:0] OFS_HIGH_ZERO = 3'h4;
  localparam logic [2:0] OFS_HIGH_ONE  = 3'h5;
  localparam logic [2:0] OFS_SPEED     = 3'h6;
  localparam logic [2:0] OFS_CLKOUT    = 3'h7;
  // control register bit positions
  localparam int BIT_TF1 = 7;
  localparam int BIT_TR1 = 6;
  localparam int BIT_TF0 = 5;
  localparam int BIT_TR0 = 4;
  localparam int BIT_IE1 = 3;
  localparam int BIT_IT1 = 2;
  localparam int BIT_IE0 = 1;
  localparam int BIT_IT0 = 0;
  // speed and clock-out bit positions
  localparam int BIT_FAST0 = 7;
  localparam int BIT_FAST1 = 6;
  localparam int BIT_CO_BAUD = 2;
  localparam int BIT_CO_ONE  = 1;
  localparam int BIT_CO_ZERO = 0;
  // reset values
  localparam logic [7:0] RST_REG = 8'h00;
  // prescale for the slow tick
  localparam int PRESCALE = 12;
  localparam logic [3:0] PRESCALE_LAST = 4'(PRESCALE - 1);
  // mode encodings
  localparam logic [1:0] MODE_13 = 2'h0;
  localparam logic [1:0] MODE_16 = 2'h1;
  localparam logic [1:0] MODE_RELOAD = 2'h2;
  localparam logic [1:0] MODE_SPLIT = 2'h3;
  // one timer's mode group
  typedef struct packed {
    logic       gate;
    logic       counter;
    logic [1:0] mode;
  } mode_group_type;
  // register port request
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_type;
endpackage

// ---- rtl/dual_timer_counter_control.sv ----
// dual timer/counter control block with register port and clock outputs
//
// The plain strobed port and the register addresses were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module dual_timer_counter_control (
  input  wire logic                  clk_sys_i,
  input  wire logic                  rst_i,
  input  wire timer_pkg::reg_req_type req_i,
  output logic [7:0]                 rdata_o,
  input  wire logic                  count_zero_pin_i,
  input  wire logic                  count_one_pin_i,
  input  wire logic                  ext_irq_zero_pin_i,
  input  wire logic                  ext_irq_one_pin_i,
  input  wire logic                  baud_overflow_i,
  input  wire logic                  vector_timer_zero_i,
  input  wire logic                  vector_timer_one_i,
  input  wire logic                  vector_ext_zero_i,
  input  wire logic                  vector_ext_one_i,
  output logic                       clkout_p10_o,
  output logic                       clkout_p34_o,
  output logic                       clkout_p35_o,
  output logic                       clkout_p10_en_o,
  output logic                       clkout_p34_en_o,
  output logic                       clkout_p35_en_o,
  output logic                       ext_irq_zero_req_o,
  output logic                       ext_irq_one_req_o
);
  import timer_pkg::*;

  // block overview:
  // - both timers share one divide-by-twelve enable; the fast bits bypass it
  // - count and interrupt pins pass two flops, then a third flop for edges
  // - counter bytes live in flops and are read one byte at a time, unlatched
  // - overflow flags and edge flags are sticky until a vector pulse clears them
  // - clock outputs are plain toggles, so their rate is half the overflow rate
  // limitation: a multi-byte read is not atomic, so software must allow for
  // a carry between reading the low byte and the high byte

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  logic [7:0]     control_ff;
  logic [7:0]     speed_ff;
  logic [7:0]     clkout_ff;
  mode_group_type mode0_ff;
  mode_group_type mode1_ff;
  logic [7:0]     low0_ff;
  logic [7:0]     high0_ff;
  logic [7:0]     low1_ff;
  logic [7:0]     high1_ff;
  logic [3:0]     pre_ff;
  logic [1:0]     sync_c0_ff;
  logic [1:0]     sync_c1_ff;
  logic [1:0]     sync_i0_ff;
  logic [1:0]     sync_i1_ff;
  logic           prev_c0_ff;
  logic           prev_c1_ff;
  logic           prev_i0_ff;
  logic           prev_i1_ff;

  logic wr_control;
  logic tick12;
  logic fall_c0;
  logic fall_c1;
  logic fall_i0;
  logic fall_i1;
  logic run0;
  logic run1;
  logic run_split;
  logic inc0;
  logic inc1;
  logic inc_split;
  logic ovf0;
  logic ovf1;
  logic ovf_split;
  logic set_tf0;
  logic set_tf1;
  logic det_i0;
  logic det_i1;
  logic [7:0] nxt_low0;
  logic [7:0] nxt_high0;
  logic [7:0] nxt_low1;
  logic [7:0] nxt_high1;

  // control writes are decoded once; the flag process and the vector clears
  // both need to know whether software owns the register in this cycle
  assign wr_control = req_i.wr && (req_i.addr == OFS_CONTROL);

  // ----------------------------------------------------------------------
  // prescaler and pin synchronisers
  // ----------------------------------------------------------------------
  // divide by twelve enable shared by both timers
  // it free-runs from reset and is never restarted by a run bit, so the
  // first slow tick after a start may come early; this keeps one divider
  // for both timers instead of one per timer
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || pre_ff == PRESCALE_LAST) begin
      pre_ff <= 4'h0;
    end else begin
      pre_ff <= pre_ff + 4'h1;
    end
  end
  assign tick12 = (pre_ff == PRESCALE_LAST);

  // two flops before any logic reads a pin
  // synchronisers and edge history reset high, the idle level of the pins,
  // so the first cycles after reset never show a false falling edge
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      sync_c0_ff <= 2'h3;
      sync_c1_ff <= 2'h3;
      sync_i0_ff <= 2'h3;
      sync_i1_ff <= 2'h3;
      prev_c0_ff <= 1'b1;
      prev_c1_ff <= 1'b1;
      prev_i0_ff <= 1'b1;
      prev_i1_ff <= 1'b1;
    end else begin
      sync_c0_ff <= {sync_c0_ff[0], count_zero_pin_i};
      sync_c1_ff <= {sync_c1_ff[0], count_one_pin_i};
      sync_i0_ff <= {sync_i0_ff[0], ext_irq_zero_pin_i};
      sync_i1_ff <= {sync_i1_ff[0], ext_irq_one_pin_i};
      prev_c0_ff <= sync_c0_ff[1];
      prev_c1_ff <= sync_c1_ff[1];
      prev_i0_ff <= sync_i0_ff[1];
      prev_i1_ff <= sync_i1_ff[1];
    end
  end
  // high sample then low sample marks one event
  // an event thus reaches the counter three clocks after the pin falls
  assign fall_c0 = prev_c0_ff && !sync_c0_ff[1];
  assign fall_c1 = prev_c1_ff && !sync_c1_ff[1];
  assign fall_i0 = prev_i0_ff && !sync_i0_ff[1];
  assign fall_i1 = prev_i1_ff && !sync_i1_ff[1];

  // ----------------------------------------------------------------------
  // count enables
  // ----------------------------------------------------------------------
  // the gate level is the synchronised pin, the same one the flag logic uses,
  // so gating and interrupt detection never disagree about the pin
  assign run0 = control_ff[BIT_TR0] && (!mode0_ff.gate || sync_i0_ff[1]);
  assign run1 = control_ff[BIT_TR1] && (!mode1_ff.gate || sync_i1_ff[1])
                && (mode1_ff.mode != MODE_SPLIT);
  // split high byte: timer only, timer 1 run bit, no gate
  assign run_split = control_ff[BIT_TR1] && (mode0_ff.mode == MODE_SPLIT);

  // event source: counter pin, else prescaled or fast internal tick
  assign inc0 = run0 && (mode0_ff.counter ? fall_c0
                        : (speed_ff[BIT_FAST0] || tick12));
  assign inc1 = run1 && (mode1_ff.counter ? fall_c1
                        : (speed_ff[BIT_FAST1] || tick12));
  assign inc_split = run_split && (speed_ff[BIT_FAST0] || tick12);

  // ----------------------------------------------------------------------
  // counter next values
  // ----------------------------------------------------------------------
  // timer 0 next value and overflow for each mode
  // the split high byte is handled after the case so it can count in the
  // same cycle as the low byte without either overwriting the other
  always_comb begin
    nxt_low0 = low0_ff;
    nxt_high0 = high0_ff;
    ovf0 = 1'b0;
    ovf_split = 1'b0;
    if (inc0) begin
      case (mode0_ff.mode)
        MODE_13: begin
          nxt_low0 = {low0_ff[7:5], low0_ff[4:0] + 5'h01};
          if (low0_ff[4:0] == 5'h1F) begin
            nxt_high0 = high0_ff + 8'h01;
            ovf0 = (high0_ff == 8'hFF);
          end
        end
        MODE_16: begin
          nxt_low0 = low0_ff + 8'h01;
          if (low0_ff == 8'hFF) begin
            nxt_high0 = high0_ff + 8'h01;
            ovf0 = (high0_ff == 8'hFF);
          end
        end
        MODE_RELOAD: begin
          ovf0 = (low0_ff == 8'hFF);
          nxt_low0 = ovf0 ? high0_ff : low0_ff + 8'h01;
        end
        default: begin
          nxt_low0 = low0_ff + 8'h01;
          ovf0 = (low0_ff == 8'hFF);
        end
      endcase
    end
    if (inc_split) begin
      nxt_high0 = high0_ff + 8'h01;
      ovf_split = (high0_ff == 8'hFF);
    end
  end

  // timer 1 next value; mode 11 never increments
  // run1 is already low in mode 11; the default branch only keeps the
  // case complete and holds the count
  always_comb begin
    nxt_low1 = low1_ff;
    nxt_high1 = high1_ff;
    ovf1 = 1'b0;
    if (inc1) begin
      case (mode1_ff.mode)
        MODE_13: begin
          nxt_low1 = {low1_ff[7:5], low1_ff[4:0] + 5'h01};
          if (low1_ff[4:0] == 5'h1F) begin
            nxt_high1 = high1_ff + 8'h01;
            ovf1 = (high1_ff == 8'hFF);
          end
        end
        MODE_16: begin
          nxt_low1 = low1_ff + 8'h01;
          if (low1_ff == 8'hFF) begin
            nxt_high1 = high1_ff + 8'h01;
            ovf1 = (high1_ff == 8'hFF);
          end
        end
        MODE_RELOAD: begin
          ovf1 = (low1_ff == 8'hFF);
          nxt_low1 = ovf1 ? high1_ff : low1_ff + 8'h01;
        end
        default: begin
          nxt_low1 = low1_ff;
        end
      endcase
    end
  end

  // software writes to a byte override the count in the same cycle
  // a carry into a byte that is written in that cycle is lost; software
  // normally stops the timer before loading it
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      low0_ff <= RST_REG;
      high0_ff <= RST_REG;
      low1_ff <= RST_REG;
      high1_ff <= RST_REG;
    end else begin
      low0_ff <= (req_i.wr && req_i.addr == OFS_LOW_ZERO) ? req_i.wdata : nxt_low0;
      high0_ff <= (req_i.wr && req_i.addr == OFS_HIGH_ZERO) ? req_i.wdata : nxt_high0;
      low1_ff <= (req_i.wr && req_i.addr == OFS_LOW_ONE) ? req_i.wdata : nxt_low1;
      high1_ff <= (req_i.wr && req_i.addr == OFS_HIGH_ONE) ? req_i.wdata : nxt_high1;
    end
  end

  // ----------------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------------
  // mode groups are split at the write so each timer decodes only its own
  // nibble; read back rebuilds the byte in the same order
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      mode0_ff <= mode_group_type'(RST_REG[3:0]);
      mode1_ff <= mode_group_type'(RST_REG[7:4]);
    end else if (req_i.wr && req_i.addr == OFS_MODE) begin
      mode1_ff <= mode_group_type'(req_i.wdata[7:4]);
      mode0_ff <= mode_group_type'(req_i.wdata[3:0]);
    end
  end

  // speed and clock-out bytes keep every bit, unused ones read back as written
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      speed_ff <= RST_REG;
      clkout_ff <= RST_REG;
    end else begin
      if (req_i.wr && req_i.addr == OFS_SPEED) begin
        speed_ff <= req_i.wdata;
      end
      if (req_i.wr && req_i.addr == OFS_CLKOUT) begin
        clkout_ff <= req_i.wdata;
      end
    end
  end

  // ----------------------------------------------------------------------
  // control register: run, type, and sticky flags
  // ----------------------------------------------------------------------
  // split high byte also sets the timer 1 flag, alongside timer 1's own overflow
  assign set_tf0 = ovf0;
  assign set_tf1 = ovf1 || ovf_split;
  // type 1: falling edge; type 0: low level, sampled every clock
  assign det_i0 = control_ff[BIT_IT0] ? fall_i0 : !sync_i0_ff[1];
  assign det_i1 = control_ff[BIT_IT1] ? fall_i1 : !sync_i1_ff[1];

  // set wins over any clear so no event is lost
  // order inside the process matters: the write goes first, the vector
  // clears next, the hardware sets last, so later assignments take priority
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      control_ff <= RST_REG;
    end else begin
      if (wr_control) begin
        control_ff <= req_i.wdata;
      end
      if (vector_timer_one_i && !wr_control) begin
        control_ff[BIT_TF1] <= 1'b0;
      end
      if (vector_timer_zero_i && !wr_control) begin
        control_ff[BIT_TF0] <= 1'b0;
      end
      if (vector_ext_one_i && !wr_control) begin
        control_ff[BIT_IE1] <= 1'b0;
      end
      if (vector_ext_zero_i && !wr_control) begin
        control_ff[BIT_IE0] <= 1'b0;
      end
      if (set_tf1) begin
        control_ff[BIT_TF1] <= 1'b1;
      end
      if (set_tf0) begin
        control_ff[BIT_TF0] <= 1'b1;
      end
      if (det_i1) begin
        control_ff[BIT_IE1] <= 1'b1;
      end
      if (det_i0) begin
        control_ff[BIT_IE0] <= 1'b1;
      end
    end
  end
  assign ext_irq_zero_req_o = control_ff[BIT_IE0];
  assign ext_irq_one_req_o = control_ff[BIT_IE1];

  // ----------------------------------------------------------------------
  // clock outputs: toggle per overflow gives half the overflow rate
  // ----------------------------------------------------------------------
  // toggles only while enabled, so a disabled output keeps its last level
  // and resumes from there; the enables double as pin output enables
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      clkout_p10_o <= 1'b0;
      clkout_p34_o <= 1'b0;
      clkout_p35_o <= 1'b0;
    end else begin
      if (baud_overflow_i && clkout_ff[BIT_CO_BAUD]) begin
        clkout_p10_o <= !clkout_p10_o;
      end
      if (ovf0 && clkout_ff[BIT_CO_ZERO]) begin
        clkout_p34_o <= !clkout_p34_o;
      end
      if (ovf1 && clkout_ff[BIT_CO_ONE]) begin
        clkout_p35_o <= !clkout_p35_o;
      end
    end
  end
  assign clkout_p10_en_o = clkout_ff[BIT_CO_BAUD];
  assign clkout_p34_en_o = clkout_ff[BIT_CO_ZERO];
  assign clkout_p35_en_o = clkout_ff[BIT_CO_ONE];

  // ----------------------------------------------------------------------
  // read port: data one cycle after the strobe
  // ----------------------------------------------------------------------
  // idle data is forced to zero so a stale value never looks like an answer
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else if (req_i.rd) begin
      case (req_i.addr)
        OFS_CONTROL:   rdata_o <= control_ff;
        OFS_MODE:      rdata_o <= {mode1_ff, mode0_ff};
        OFS_LOW_ZERO:  rdata_o <= low0_ff;
        OFS_LOW_ONE:   rdata_o <= low1_ff;
        OFS_HIGH_ZERO: rdata_o <= high0_ff;
        OFS_HIGH_ONE:  rdata_o <= high1_ff;
        OFS_SPEED:     rdata_o <= speed_ff;
        default:       rdata_o <= clkout_ff;
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end
endmodule
`default_nettype wire

// ---- sim/pin_partner.sv ----
// far-side model: count pin, interrupt pins and baud overflow pulses
`timescale 1ns/100ps
`default_nettype none
module pin_partner (
  input  wire logic       clk_sys_i,
  input  wire logic       rst_i,
  input  wire logic       count_run_i,
  input  wire logic [1:0] ext_lvl_i,
  output logic            count_pin_o,
  output logic [1:0]      ext_pin_o,
  output logic            baud_ovf_o,
  output int              falls_o
);
  logic [4:0] ph_ff;
  logic [2:0] bc_ff;
  // each level held a full 12-clock machine cycle so every level is sampled
  always_ff @(posedge clk_sys_i) begin
    ph_ff <= (rst_i || !count_run_i || ph_ff == 5'h17) ? 5'h00 : ph_ff + 5'h01;
    bc_ff <= (rst_i || bc_ff == 3'h4) ? 3'h0 : bc_ff + 3'h1;
    if (rst_i) begin
      falls_o <= 0;
    end else if (count_run_i && ph_ff == 5'h0B) begin
      falls_o <= falls_o + 1;
    end
  end
  // idle pin rests high, so stopping never makes a falling edge
  assign count_pin_o = (ph_ff < 5'h0C);
  assign ext_pin_o = ext_lvl_i;
  assign baud_ovf_o = (bc_ff == 3'h4);
endmodule
`default_nettype wire

// ---- sim/dual_timer_monitor.sv ----
// concurrent checks on the dual timer control block ports
`timescale 1ns/100ps
`default_nettype none
module dual_timer_monitor
  import timer_pkg::*;
(
  input wire logic                   clk_sys_i,
  input wire logic                   rst_i,
  input wire timer_pkg::reg_req_type req_i,
  input wire logic [7:0]             rdata_o,
  input wire logic                   ext_irq_zero_pin_i,
  input wire logic                   baud_overflow_i,
  input wire logic                   vector_ext_zero_i,
  input wire logic                   clkout_p10_o,
  input wire logic                   clkout_p10_en_o,
  input wire logic                   clkout_p35_en_o,
  input wire logic                   ext_irq_zero_req_o,
  input wire logic                   ext_irq_one_req_o
);
  logic      it0_ff;
  wire logic ctl_wr = req_i.wr && (req_i.addr == OFS_CONTROL);
  wire logic out_wr = req_i.wr && (req_i.addr == OFS_CLKOUT);
  // shadow of the trigger type, which the checker cannot see otherwise
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      it0_ff <= 1'b0;
    end else if (ctl_wr) begin
      it0_ff <= req_i.wdata[BIT_IT0];
    end
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  // ----------------------------------------
  // sequences and assertions
  // ----------------------------------------
  sequence quiet_high; ext_irq_zero_pin_i [*5]; endsequence
  sequence level_low; (!it0_ff && !ext_irq_zero_pin_i) [*4]; endsequence
  a_rdata_idle: assert property (!req_i.rd |=> rdata_o == 8'h00)
    else $error("read data not idle");
  a_rdata_flags: assert property (req_i.rd && req_i.addr == OFS_CONTROL |=>
    rdata_o[BIT_IE0] == $past(ext_irq_zero_req_o) && rdata_o[BIT_IE1] == $past(ext_irq_one_req_o))
    else $error("edge flags misread");
  a_baud_en_write: assert property (out_wr |=>
    clkout_p10_en_o == $past(req_i.wdata[BIT_CO_BAUD])) else $error("baud enable wrong");
  a_one_en_hold: assert property (!out_wr |=> $stable(clkout_p35_en_o))
    else $error("timer one enable moved");
  a_baud_toggle: assert property (baud_overflow_i && clkout_p10_en_o |=>
    clkout_p10_o != $past(clkout_p10_o)) else $error("baud clock not toggled");
  a_baud_hold: assert property (!baud_overflow_i && clkout_p10_en_o && !out_wr |=>
    $stable(clkout_p10_o)) else $error("baud clock moved");
  a_level_set: assert property (level_low |=> ext_irq_zero_req_o)
    else $error("low level not flagged");
  a_edge_set: assert property (it0_ff && $fell(ext_irq_zero_pin_i) |->
    ##[1:4] ext_irq_zero_req_o) else $error("falling edge not flagged");
  a_vector_clear: assert property (quiet_high ##0 (vector_ext_zero_i && !ctl_wr) |=>
    !ext_irq_zero_req_o) else $error("flag not cleared");
endmodule
bind dual_timer_counter_control dual_timer_monitor dual_timer_monitor_i (
  .clk_sys_i(clk_sys_i), .rst_i(rst_i), .req_i(req_i), .rdata_o(rdata_o),
  .ext_irq_zero_pin_i(ext_irq_zero_pin_i), .baud_overflow_i(baud_overflow_i),
  .vector_ext_zero_i(vector_ext_zero_i), .clkout_p10_o(clkout_p10_o),
  .clkout_p10_en_o(clkout_p10_en_o), .clkout_p35_en_o(clkout_p35_en_o),
  .ext_irq_zero_req_o(ext_irq_zero_req_o), .ext_irq_one_req_o(ext_irq_one_req_o));
`default_nettype wire

// ---- sim/tb_top.sv ----
// self-checking bench for the dual timer control block
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
  $display("[FAIL] %0t mismatch got %h exp %h", $time, g, e); end end
module tb_top;
  import timer_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  reg_req_type req = '0;
  logic [7:0]  rdata, d;
  logic        cpin, bovf, p10, p34, p35, e10, e34, e35, irq0, irq1;
  logic        crun = 1'b0;
  logic        rd_seen = 1'b0;
  logic [1:0]  lvl = 2'b11;
  logic [1:0]  epin;
  logic [3:0]  vec = '0;
  logic [2:0]  adr[3] = '{OFS_MODE, OFS_SPEED, OFS_CLKOUT};
  logic [7:0]  exp_q[$];
  int          falls;
  int          num_errors = 0;
  int          samples_checked = 0;
  int          seed = 63;
  always #50 clk = ~clk;
  dual_timer_counter_control dual_timer_counter_control_i (
    .clk_sys_i(clk), .rst_i(rst), .req_i(req), .rdata_o(rdata),
    .count_zero_pin_i(cpin), .count_one_pin_i(cpin),
    .ext_irq_zero_pin_i(epin[0]), .ext_irq_one_pin_i(epin[1]), .baud_overflow_i(bovf),
    .vector_timer_zero_i(vec[0]), .vector_timer_one_i(vec[1]),
    .vector_ext_zero_i(vec[2]), .vector_ext_one_i(vec[3]),
    .clkout_p10_o(p10), .clkout_p34_o(p34), .clkout_p35_o(p35), .clkout_p10_en_o(e10),
    .clkout_p34_en_o(e34), .clkout_p35_en_o(e35),
    .ext_irq_zero_req_o(irq0), .ext_irq_one_req_o(irq1));
  pin_partner pin_partner_i (
    .clk_sys_i(clk), .rst_i(rst), .count_run_i(crun), .ext_lvl_i(lvl),
    .count_pin_o(cpin), .ext_pin_o(epin), .baud_ovf_o(bovf), .falls_o(falls));
  // read answers are paired with the oldest noted expectation
  always @(posedge clk) begin
    if (rd_seen) `CHK(rdata, exp_q.pop_front())
    rd_seen <= req.rd;
  end
  task automatic reg_wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk) req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk) req <= '0;
  endtask
  task automatic reg_rd(input logic [2:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge clk) req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk) req <= '0;
  endtask
  // run the timers for n+4 clocks, reading control just before the stop
  task automatic run(input logic [7:0] go, input int n, input logic [7:0] mid, stp);
    reg_wr(OFS_CONTROL, go);
    repeat (n) @(posedge clk);
    reg_rd(OFS_CONTROL, mid);
    reg_wr(OFS_CONTROL, stp);
  endtask
  task automatic pulse(input int k);
    @(posedge clk) vec[k] <= 1'b1;
    @(posedge clk) vec[k] <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic conclude;
    $display("num_errors %0d samples_checked %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // hang guard: the whole sequence needs well under 2000 clocks
  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    conclude();
  end
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a < 8; a++) reg_rd(3'(a), RST_REG);
    foreach (adr[i]) begin
      d = 8'($random(seed));
      reg_wr(adr[i], d);
      reg_rd(adr[i], d);
    end
    reg_wr(OFS_MODE, 8'h11);
    reg_wr(OFS_SPEED, 8'h80);
    run(8'h50, 56, 8'h50, 8'h00);
    reg_rd(OFS_LOW_ZERO, 8'h3C);
    reg_rd(OFS_LOW_ONE, 8'h05);
    reg_wr(OFS_MODE, 8'h10);
    reg_wr(OFS_LOW_ZERO, 8'hFD);
    reg_wr(OFS_HIGH_ZERO, 8'hFF);
    reg_wr(OFS_CLKOUT, 8'h03);
    run(8'h10, 4, 8'h30, 8'h20);
    reg_rd(OFS_LOW_ZERO, 8'hE5);
    reg_rd(OFS_HIGH_ZERO, 8'h00);
    `CHK(p34, 1'b1)
    `CHK(e34, 1'b1)
    `CHK(e35, 1'b1)
    pulse(0);
    reg_rd(OFS_CONTROL, 8'h00);
    reg_wr(OFS_SPEED, 8'hC0);
    reg_wr(OFS_MODE, 8'h20);
    reg_wr(OFS_LOW_ONE, 8'hFE);
    reg_wr(OFS_HIGH_ONE, 8'hFD);
    run(8'h40, 4, 8'hC0, 8'h80);
    reg_rd(OFS_LOW_ONE, 8'hFD);
    reg_rd(OFS_HIGH_ONE, 8'hFD);
    `CHK(p35, 1'b1)
    pulse(1);
    reg_rd(OFS_CONTROL, 8'h00);
    reg_wr(OFS_MODE, 8'h30);
    run(8'h40, 20, 8'h40, 8'h00);
    reg_rd(OFS_LOW_ONE, 8'hFD);
    reg_wr(OFS_MODE, 8'h33);
    reg_wr(OFS_HIGH_ZERO, 8'hFE);
    run(8'h40, 4, 8'hC0, 8'h80);
    reg_rd(OFS_HIGH_ZERO, 8'h06);
    reg_rd(OFS_LOW_ZERO, 8'hE5);
    reg_wr(OFS_MODE, 8'h09);
    reg_wr(OFS_LOW_ZERO, 8'h00);
    reg_wr(OFS_HIGH_ZERO, 8'h00);
    lvl[0] <= 1'b0;
    run(8'h10, 4, 8'h12, 8'h00);
    reg_rd(OFS_LOW_ZERO, 8'h00);
    lvl[0] <= 1'b1;
    repeat (4) @(posedge clk);
    run(8'h10, 4, 8'h10, 8'h00);
    reg_rd(OFS_LOW_ZERO, 8'h08);
    reg_wr(OFS_MODE, 8'h50);
    reg_wr(OFS_LOW_ONE, 8'h00);
    reg_wr(OFS_HIGH_ONE, 8'h00);
    reg_wr(OFS_CONTROL, 8'h40);
    @(posedge clk) crun <= 1'b1;
    repeat (200) @(posedge clk);
    crun <= 1'b0;
    repeat (30) @(posedge clk);
    reg_rd(OFS_LOW_ONE, 8'(falls));
    reg_wr(OFS_CONTROL, 8'h05);
    reg_rd(OFS_CONTROL, 8'h05);
    lvl[0] <= 1'b0;
    repeat (6) @(posedge clk);
    lvl[0] <= 1'b1;
    repeat (6) @(posedge clk);
    `CHK(irq0, 1'b1)
    pulse(2);
    `CHK(irq0, 1'b0)
    reg_wr(OFS_CONTROL, 8'h01);
    lvl[1] <= 1'b0;
    repeat (6) @(posedge clk);
    pulse(3);
    `CHK(irq1, 1'b1)
    lvl[1] <= 1'b1;
    conclude();
  end
endmodule
`default_nettype wire
